/* logic/line_hook_pkg.sv */
// shared constants and types for the line hook / termination controller
package line_hook_pkg;
	// register indices; byte address is four times the index
	localparam logic [4:0] IDX_HOOK = 5'h05;
	localparam logic [4:0] IDX_LINK = 5'h06;
	localparam logic [4:0] IDX_TERM = 5'h10;
	localparam logic [4:0] IDX_CFG = 5'h12;
	localparam logic [4:0] IDX_STAT = 5'h13;
	// hook register fields
	localparam int HOOK_CTL_POS = 0;
	localparam int HOOK_PEN_POS = 1;
	localparam int HOOK_MON_POS = 3;
	// link register fields
	localparam int LINK_PD_POS = 3;
	// termination register fields
	localparam int TERM_DC_POS = 0;
	localparam int TERM_AC_POS = 2;
	// config register fields
	localparam int CFG_MEAS_POS = 2;
	localparam int CFG_VADJ_POS = 4;
	// status register fields
	localparam int STAT_DROP_POS = 1;
	localparam int STAT_SENSE_POS = 3;
	localparam int STAT_VALID_POS = 0;
	// reset values
	localparam logic [1:0] DC_TERM_RST = 2'h2;
	localparam logic LINK_PD_RST = 1'b1;
	// dc termination modes
	localparam logic [1:0] DC_LOWEST = 2'h0;
	localparam logic [1:0] DC_LOWER = 2'h1;
	localparam logic [1:0] DC_STANDARD = 2'h2;
	localparam logic [1:0] DC_LIMIT = 2'h3;
	// sense scaling: voltage input in 50 mV steps, current in mA
	localparam int V_FIRST_STEP = 60;
	localparam int V_STEP = 55;
	localparam int I_STEP = 3;
	localparam int I_OVL_MA = 140;
	localparam int I_OVL_LIMIT_MA = 56;
	localparam logic [4:0] CODE_ZERO = 5'h00;
	localparam logic [4:0] CODE_MIN = 5'h01;
	localparam logic [4:0] CODE_OVL = 5'h1F;
	// off-hook settling in sample periods, including filter delay
	localparam int SETTLE_FS = 1548;
	localparam int GROUP_DELAY_FS = 12;
	// AHB-Lite
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// analog front-end readings
	typedef struct packed {
		logic [10:0] volt;
		logic [7:0] curr_ma;
		logic present;
		logic [4:0] monitor;
	} afe_in_t;
	// termination controls towards the line side
	typedef struct packed {
		logic hook_switch_on;
		logic [1:0] dc_term_select;
		logic ac_term_select;
		logic voltage_adjust_bit;
		logic current_limit_on;
	} term_out_t;
	typedef enum logic [1:0] {
		ST_ONHOOK,
		ST_SETTLE,
		ST_READY
	} hook_state_t;
endpackage

/* logic/line_hook_termination_ctrl.sv */
// line hook, termination select and line sense controller
`timescale 1ns/100ps
`default_nettype none
module line_hook_termination_ctrl
	import line_hook_pkg::*;
#(
	parameter int SETTLE = SETTLE_FS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// sample-rate tick from the clock generator
	input wire logic fs_tick,
	// hook request pin, active low
	input wire logic hook_request_n,
	// analog front-end readings
	input wire afe_in_t afe_in,
	// line side controls and status
	output term_out_t term_out,
	output logic line_data_valid
);
	// registers
	logic hook_control_bit_ff, nxt_hook_control_bit;
	logic hook_pin_enable_ff, nxt_hook_pin_enable;
	logic onhook_monitor_enable_ff, nxt_onhook_monitor_enable;
	logic link_powerdown_ff, nxt_link_powerdown;
	logic [1:0] dc_term_select_ff, nxt_dc_term_select;
	logic ac_term_select_ff, nxt_ac_term_select;
	logic meas_select_ff, nxt_meas_select;
	logic voltage_adjust_bit_ff, nxt_voltage_adjust_bit;
	// bus pipeline
	logic wr_pend_ff, nxt_wr_pend;
	logic [4:0] wr_idx_ff, nxt_wr_idx;
	logic [31:0] hrdata_ff, nxt_hrdata;
	// pin synchroniser
	logic [2:0] pin_sync_ff, nxt_pin_sync;
	logic pin_low_ff, nxt_pin_low;
	// hook sequencing
	hook_state_t state_ff, nxt_state;
	logic [10:0] settle_ff, nxt_settle;
	// sense and line outputs
	logic [4:0] line_sense_code_ff, nxt_line_sense_code;
	logic line_dropout_flag_ff, nxt_line_dropout_flag;
	term_out_t term_ff, nxt_term;

	logic addr_ok;
	logic [4:0] addr_idx;
	logic off_hook_req;
	logic [4:0] volt_code;
	logic [4:0] curr_code;
	logic [30:0] v_therm;
	logic [29:0] i_therm;
	logic [7:0] ovl_ma;

	assign addr_idx = haddr[6:2];
	assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;

	// bus registers
	always_comb begin
		nxt_hook_control_bit = hook_control_bit_ff;
		nxt_hook_pin_enable = hook_pin_enable_ff;
		nxt_onhook_monitor_enable = onhook_monitor_enable_ff;
		nxt_link_powerdown = link_powerdown_ff;
		nxt_dc_term_select = dc_term_select_ff;
		nxt_ac_term_select = ac_term_select_ff;
		nxt_meas_select = meas_select_ff;
		nxt_voltage_adjust_bit = voltage_adjust_bit_ff;
		nxt_wr_pend = addr_ok && hwrite;
		nxt_wr_idx = addr_ok ? addr_idx : wr_idx_ff;
		nxt_hrdata = hrdata_ff;
		if (wr_pend_ff) begin
			case (wr_idx_ff)
				IDX_HOOK: begin
					nxt_hook_control_bit = hwdata[HOOK_CTL_POS];
					nxt_hook_pin_enable = hwdata[HOOK_PEN_POS];
					nxt_onhook_monitor_enable = hwdata[HOOK_MON_POS];
				end
				IDX_LINK: nxt_link_powerdown = hwdata[LINK_PD_POS];
				IDX_TERM: begin
					nxt_dc_term_select = hwdata[TERM_DC_POS +: 2];
					nxt_ac_term_select = hwdata[TERM_AC_POS];
				end
				IDX_CFG: begin
					nxt_meas_select = hwdata[CFG_MEAS_POS];
					nxt_voltage_adjust_bit = hwdata[CFG_VADJ_POS];
				end
				default: ;
			endcase
		end
		// read data is captured in the address phase, so a read right
		// after a write to the same register returns the old value
		if (addr_ok && !hwrite) begin
			nxt_hrdata = 32'h0000_0000;
			if (haddr[31:7] == 25'h000_0000) begin
				case (addr_idx)
					IDX_HOOK: begin
						nxt_hrdata[HOOK_CTL_POS] = hook_control_bit_ff;
						nxt_hrdata[HOOK_PEN_POS] = hook_pin_enable_ff;
						nxt_hrdata[HOOK_MON_POS] = onhook_monitor_enable_ff;
					end
					IDX_LINK: nxt_hrdata[LINK_PD_POS] = link_powerdown_ff;
					IDX_TERM: begin
						nxt_hrdata[TERM_DC_POS +: 2] = dc_term_select_ff;
						nxt_hrdata[TERM_AC_POS] = ac_term_select_ff;
					end
					IDX_CFG: begin
						nxt_hrdata[CFG_MEAS_POS] = meas_select_ff;
						nxt_hrdata[CFG_VADJ_POS] = voltage_adjust_bit_ff;
					end
					IDX_STAT: begin
						nxt_hrdata[STAT_SENSE_POS +: 5] = line_sense_code_ff;
						nxt_hrdata[STAT_DROP_POS] = line_dropout_flag_ff;
						nxt_hrdata[STAT_VALID_POS] = line_data_valid;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hook_control_bit_ff <= 1'b0;
			hook_pin_enable_ff <= 1'b0;
			onhook_monitor_enable_ff <= 1'b0;
			link_powerdown_ff <= LINK_PD_RST;
			dc_term_select_ff <= DC_TERM_RST;
			ac_term_select_ff <= 1'b0;
			meas_select_ff <= 1'b0;
			voltage_adjust_bit_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 5'h00;
			hrdata_ff <= 32'h0000_0000;
		end else begin
			hook_control_bit_ff <= nxt_hook_control_bit;
			hook_pin_enable_ff <= nxt_hook_pin_enable;
			onhook_monitor_enable_ff <= nxt_onhook_monitor_enable;
			link_powerdown_ff <= nxt_link_powerdown;
			dc_term_select_ff <= nxt_dc_term_select;
			ac_term_select_ff <= nxt_ac_term_select;
			meas_select_ff <= nxt_meas_select;
			voltage_adjust_bit_ff <= nxt_voltage_adjust_bit;
			wr_pend_ff <= nxt_wr_pend;
			wr_idx_ff <= nxt_wr_idx;
			hrdata_ff <= nxt_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	// hook pin: three stages, a change counts once stages two and three agree
	always_comb begin
		nxt_pin_sync = {pin_sync_ff[1:0], hook_request_n};
		nxt_pin_low = pin_low_ff;
		if (pin_sync_ff[1] == pin_sync_ff[2])
			nxt_pin_low = !pin_sync_ff[2];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_sync_ff <= 3'h7;
			pin_low_ff <= 1'b0;
		end else begin
			pin_sync_ff <= nxt_pin_sync;
			pin_low_ff <= nxt_pin_low;
		end
	end

	// pin only counts when enabled; either source seizes the line
	assign off_hook_req = hook_control_bit_ff ||
		(hook_pin_enable_ff && pin_low_ff);

	// voltage code: first step at 3 V, then 2.75 V per code
	// current code: 3 mA per code, floor at one when usable
	for (genvar k = 0; k < 31; k++) begin : g_volt
		assign v_therm[k] = afe_in.volt >=
			11'(V_FIRST_STEP + k * V_STEP);
	end
	for (genvar k = 0; k < 30; k++) begin : g_curr
		assign i_therm[k] = afe_in.curr_ma >= 8'((k + 1) * I_STEP);
	end

	always_comb begin
		volt_code = CODE_ZERO;
		curr_code = CODE_ZERO;
		for (int k = 0; k < 31; k++)
			volt_code = volt_code + {4'h0, v_therm[k]};
		for (int k = 0; k < 30; k++)
			curr_code = curr_code + {4'h0, i_therm[k]};
		ovl_ma = (dc_term_select_ff == DC_LIMIT) ? 8'(I_OVL_LIMIT_MA) :
			8'(I_OVL_MA);
		if (!afe_in.present)
			curr_code = CODE_ZERO;
		else if (afe_in.curr_ma > ovl_ma)
			curr_code = CODE_OVL;
		else if (curr_code == CODE_ZERO)
			curr_code = CODE_MIN;
	end

	// hook sequencing and settle count in sample periods
	always_comb begin
		nxt_state = state_ff;
		nxt_settle = settle_ff;
		case (state_ff)
			ST_ONHOOK: begin
				nxt_settle = 11'(SETTLE - 1);
				if (off_hook_req && !link_powerdown_ff)
					nxt_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (fs_tick) begin
					if (settle_ff == 11'h000)
						nxt_state = ST_READY;
					else
						nxt_settle = settle_ff - 11'h001;
				end
			end
			ST_READY: ;
			default: nxt_state = ST_ONHOOK;
		endcase
		// dropping the request or the link restarts from on-hook
		if (!off_hook_req || link_powerdown_ff)
			nxt_state = ST_ONHOOK;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_ONHOOK;
			settle_ff <= 11'h000;
		end else begin
			state_ff <= nxt_state;
			settle_ff <= nxt_settle;
		end
	end

	assign line_data_valid = state_ff == ST_READY;

	// sense field and termination selects update on sample ticks; the hook switch follows every cycle
	always_comb begin
		nxt_line_sense_code = line_sense_code_ff;
		nxt_line_dropout_flag = line_dropout_flag_ff;
		nxt_term = term_ff;
		if (fs_tick) begin
			nxt_term.dc_term_select = dc_term_select_ff;
			nxt_term.ac_term_select = ac_term_select_ff;
			nxt_term.voltage_adjust_bit = voltage_adjust_bit_ff;
			nxt_term.current_limit_on = dc_term_select_ff == DC_LIMIT;
			nxt_line_dropout_flag = 1'b0;
			if (link_powerdown_ff) begin
				nxt_line_sense_code = CODE_ZERO;
			end else if (off_hook_req) begin
				nxt_line_sense_code = curr_code;
				nxt_line_dropout_flag = curr_code == CODE_ZERO &&
					!afe_in.present;
			end else if (meas_select_ff) begin
				nxt_line_sense_code = volt_code;
			end else if (onhook_monitor_enable_ff) begin
				nxt_line_sense_code = afe_in.monitor;
			end else begin
				nxt_line_sense_code = CODE_ZERO;
			end
		end
		nxt_term.hook_switch_on = off_hook_req && !link_powerdown_ff;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			line_sense_code_ff <= CODE_ZERO;
			line_dropout_flag_ff <= 1'b0;
			term_ff <= '{hook_switch_on: 1'b0, dc_term_select: DC_TERM_RST,
				ac_term_select: 1'b0, voltage_adjust_bit: 1'b0,
				current_limit_on: 1'b0};
		end else begin
			line_sense_code_ff <= nxt_line_sense_code;
			line_dropout_flag_ff <= nxt_line_dropout_flag;
			term_ff <= nxt_term;
		end
	end

	assign term_out = term_ff;
endmodule // line_hook_termination_ctrl
`default_nettype wire

/* testbench/line_hook_assertions.sv */
// port-level checks for the hook and termination controller
`timescale 1ns/100ps
`default_nettype none
module line_hook_assertions
	import line_hook_pkg::*;
#(
	parameter int SETTLE = SETTLE_FS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// line side
	input wire logic fs_tick,
	input wire term_out_t term_out,
	input wire logic line_data_valid
);
	logic [10:0] tick_cnt_ff;
	logic [10:0] nxt_tick_cnt;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// sample ticks since the switch closed; saturates so it never wraps
	always_comb begin
		nxt_tick_cnt = tick_cnt_ff;
		if (!term_out.hook_switch_on)
			nxt_tick_cnt = '0;
		else if (fs_tick && tick_cnt_ff != 11'h7FF)
			nxt_tick_cnt = tick_cnt_ff + 11'h001;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= nxt_tick_cnt;
	end
	sequence rd_at(logic [31:0] a);
		hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr == a;
	endsequence
	a_valid_needs_switch: assert property (
		line_data_valid |-> term_out.hook_switch_on)
		else $error("data valid with switch open");
	a_close_not_valid: assert property (
		$rose(term_out.hook_switch_on) |-> !line_data_valid [*2])
		else $error("data valid right at switch close");
	a_dc_on_tick: assert property (
		$changed(term_out.dc_term_select) |-> $past(fs_tick))
		else $error("dc mode moved off a sample tick");
	a_ac_on_tick: assert property (
		$changed(term_out.ac_term_select) |-> $past(fs_tick))
		else $error("ac mode moved off a sample tick");
	a_limit_mode: assert property (
		term_out.current_limit_on == (term_out.dc_term_select == DC_LIMIT))
		else $error("current limit not tied to mode 11");
	a_settle_early: assert property (
		$rose(line_data_valid) |-> tick_cnt_ff >= SETTLE - 1
		&& tick_cnt_ff <= SETTLE + 1)
		else $error("settling count wrong");
	a_settle_late: assert property (
		term_out.hook_switch_on && tick_cnt_ff > SETTLE + 1 |-> line_data_valid)
		else $error("data valid never came");
	a_status_valid: assert property (
		rd_at(32'h4C) |=> hrdata[0] == $past(line_data_valid))
		else $error("status valid bit disagrees");
endmodule // line_hook_assertions
bind line_hook_termination_ctrl line_hook_assertions #(.SETTLE(SETTLE))
	u_chk (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .fs_tick, .term_out, .line_data_valid);
`default_nettype wire

/* testbench/line_model.sv */
// line-side stand-in: sample tick and front-end readings
`timescale 1ns/100ps
`default_nettype none
module line_model
	import line_hook_pkg::*;
#(
	// a short sample period keeps off-hook settling short in simulation
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// readings chosen by the bench
	input wire logic [10:0] volt,
	input wire logic [7:0] curr_ma,
	input wire logic present,
	// towards the controller
	output logic fs_tick,
	output afe_in_t afe_in
);
	int div_cnt;
	// readings only move on a tick, like a real converter output
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 0;
			fs_tick <= 1'b0;
			afe_in <= '0;
		end else begin
			div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
			fs_tick <= (div_cnt == DIV - 1);
			if (fs_tick)
				afe_in <= {volt, curr_ma, present, 5'h15};
		end
	end
endmodule // line_model
`default_nettype wire

/* testbench/line_hook_termination_ctrl_tb_top.sv */
// self-checking bench for the hook and termination controller
`timescale 1ns/100ps
`default_nettype none
module line_hook_termination_ctrl_tb_top;
	import line_hook_pkg::*;
	localparam int VT[7] = '{59, 60, 114, 115, 1709, 1710, 2047};
	localparam int VC[7] = '{0, 1, 1, 2, 30, 31, 31};
	localparam int CU[8] = '{0, 0, 5, 30, 90, 141, 56, 57};
	localparam int PR[8] = '{0, 1, 1, 1, 1, 1, 1, 1};
	localparam int DM[8] = '{2, 2, 2, 2, 2, 2, 3, 3};
	localparam int ST[8] = '{3, 9, 9, 81, 241, 249, 145, 249};
	logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, fs_tick;
	logic hook_request_n, line_data_valid, present;
	logic [31:0] haddr, hwdata, hrdata, rd_val;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [10:0] volt;
	logic [7:0] curr_ma;
	logic [4:0] exp_term;
	afe_in_t afe_in;
	term_out_t term_out;
	int err_total, checks, cyc;
	assign hready = hreadyout;
	line_model u_line_model (.core_clk, .rst, .volt, .curr_ma, .present,
		.fs_tick, .afe_in);
	line_hook_termination_ctrl #(.SETTLE(5)) u_line_hook_termination_ctrl (
		.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .fs_tick, .hook_request_n,
		.afe_in, .term_out, .line_data_valid);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd_val = hrdata;
		chk("hresp", hresp, 32'h0);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge fs_tick);
		@(posedge core_clk);
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		{rst, hook_request_n, present} = 3'h7;
		{hsel, hwrite, htrans, haddr, hwdata, volt, curr_ma} = '0;
		hsize = 3'h2;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, 32'h40, 32'h0);
		chk("term_reset", rd_val, 32'h2);
		bus(1'b0, 32'h18, 32'h0);
		chk("link_reset", rd_val[3], 32'h1);
		bus(1'b0, 32'h7C, 32'h0);
		chk("unmapped", rd_val, 32'h0);
		bus(1'b1, 32'h14, 32'h1);
		ticks(3);
		chk("pd_switch", term_out.hook_switch_on, 32'h0);
		bus(1'b1, 32'h14, 32'h0);
		bus(1'b1, 32'h18, 32'h0);
		bus(1'b1, 32'h48, 32'h4);
		for (int i = 0; i < 7; i++) begin
			volt <= 11'(VT[i]);
			ticks(3);
			bus(1'b0, 32'h4C, 32'h0);
			chk("volt_code", rd_val[7:3], VC[i]);
		end
		bus(1'b1, 32'h48, 32'h0);
		bus(1'b1, 32'h14, 32'h8);
		ticks(3);
		bus(1'b0, 32'h4C, 32'h0);
		chk("monitor", rd_val[7:3], 32'h15);
		bus(1'b1, 32'h14, 32'h0);
		ticks(3);
		bus(1'b0, 32'h4C, 32'h0);
		chk("sense_idle", rd_val[7:3], 32'h0);
		// monitor is off a full sample period before the pin goes low
		ticks(1);
		hook_request_n <= 1'b0;
		ticks(3);
		chk("pin_disabled", term_out.hook_switch_on, 32'h0);
		bus(1'b1, 32'h14, 32'h2);
		// look a little after each edge so the state register has settled
		for (int k = 0; k < 200 && line_data_valid !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
		end
		chk("pin_switch", term_out.hook_switch_on, 32'h1);
		chk("settled", line_data_valid, 32'h1);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 32'h40, 32'(DM[i]));
			curr_ma <= 8'(CU[i]);
			present <= PR[i][0];
			ticks(3);
			bus(1'b0, 32'h4C, 32'h0);
			chk("loop_code", rd_val[7:0], ST[i]);
		end
		// limiting mode on a weak loop: host falls back to the default mode
		curr_ma <= 8'h0F;
		ticks(3);
		bus(1'b0, 32'h4C, 32'h0);
		chk("weak_loop", rd_val[7:3], 32'h5);
		if (rd_val[7:3] < 5'h06)
			bus(1'b1, 32'h40, 32'h2);
		ticks(2);
		chk("limit_exit", term_out.dc_term_select, 32'h2);
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, 32'h40, 32'(m));
			bus(1'b1, 32'h48, 32'(m[0]) << 4);
			ticks(2);
			exp_term = {m[1:0], m[2], m[0], m[1:0] == 2'h3};
			chk("term", term_out[4:0], exp_term);
		end
		hook_request_n <= 1'b1;
		ticks(3);
		chk("pin_release", line_data_valid, 32'h0);
		chk("switch_open", term_out.hook_switch_on, 32'h0);
		// low-voltage start: lowest mode, adjust bit set, then pick by code
		bus(1'b1, 32'h40, 32'h0);
		bus(1'b1, 32'h48, 32'h10);
		curr_ma <= 8'h0C;
		bus(1'b1, 32'h14, 32'h1);
		ticks(8);
		bus(1'b0, 32'h4C, 32'h0);
		chk("low_volt_code", rd_val[7:0], 32'h21);
		if (rd_val[7:3] > 5'h02 && rd_val[7:3] < 5'h06)
			bus(1'b1, 32'h40, 32'h1);
		ticks(2);
		chk("low_volt_mode", term_out[4:1], 32'h5);
		// seize in the lower mode, later hold in the default one
		ticks(20);
		bus(1'b1, 32'h40, 32'h2);
		ticks(2);
		chk("hold_mode", term_out[4:1], 32'h9);
		close_out();
	end
endmodule // line_hook_termination_ctrl_tb_top
`default_nettype wire
